/* File: core/rsp_regs.vh */
`ifndef RSP_REGS_VH
`define RSP_REGS_VH
// Baud selection codes
`define RSP_BAUD_4800    3'h0
`define RSP_BAUD_9600    3'h1
`define RSP_BAUD_19200   3'h2
`define RSP_BAUD_38400   3'h3
`define RSP_BAUD_57600   3'h4
`define RSP_BAUD_115200  3'h5
// Flow-control mode codes
`define RSP_FLOW_NONE    3'h0
`define RSP_FLOW_XONXOFF 3'h1
`define RSP_FLOW_DTRDSR  3'h2
`define RSP_FLOW_RTSCTS  3'h3
`define RSP_FLOW_MODEM   3'h4
// In-band control characters
`define RSP_CHAR_XOFF    8'h13
`define RSP_CHAR_XON     8'h11
// Receive fill thresholds
`define RSP_RX_HIGH      8'h64
`define RSP_RX_LOW       8'h50
// Clock rate in Hz
`define RSP_CLK_HZ       125000000
// Oversample-by-16 tick divisors per rate (one tick every divisor+1 clocks)
`define RSP_DIV_4800     16'h065b
`define RSP_DIV_9600     16'h032d
`define RSP_DIV_19200    16'h0196
`define RSP_DIV_38400    16'h00cb
`define RSP_DIV_57600    16'h0087
`define RSP_DIV_115200   16'h0043
`endif

/* File: core/rsp_rx_mem.v */
`default_nettype none
// Receive buffer storage, registered read data
module rsp_rx_mem #(
  parameter AW = 7
) (
  input  wire         clk_i,
  input  wire         we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [7:0]   wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [7:0]   rdata_o
);
  reg [7:0] mem [0:(1<<AW)-1];

  // Storage and registered read port
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // rsp_rx_mem
`default_nettype wire

/* File: core/rsp_port.v */
`include "rsp_regs.vh"
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Line rate selectable among 4800 to 115200 baud; current rate readable.
// - Rate and mode held in storage untouched by any reset.
// - No-flow mode sends and receives without throttling.
// - Software mode: received 13h suspends transmission after current char.
// - Software mode: received 11h resumes transmission.
// - DTR/DSR mode: transmit only while DSR true.
// - DTR/DSR mode: DTR false near 100 buffered chars, true when space frees.
// - RTS/CTS mode: transmit only while CTS true.
// - RTS/CTS mode: RTS false near 100 buffered chars, true when space frees.
// - Mode readback reports none, software, DTR/DSR, RTS/CTS or modem.
module rsp_port #(
  parameter AW = 7
) (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       cfg_we_i,
  input  wire [2:0] cfg_baud_i,
  input  wire [2:0] cfg_flow_i,
  output reg  [2:0] baud_o,
  output reg  [2:0] flow_o,
  input  wire       tx_valid_i,
  input  wire [7:0] tx_data_i,
  output reg        tx_ready_o,
  output reg        rx_valid_o,
  output reg  [7:0] rx_data_o,
  input  wire       rx_ready_i,
  output reg        rx_overrun_o,
  output reg        txd_o,
  input  wire       rxd_i,
  input  wire       dsr_i,
  input  wire       cts_i,
  output reg        dtr_o,
  output reg        rts_o
);
  //////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  reg [1:0] rst_sync;
  wire      rst_n = rst_sync[1];
  reg [2:0] s1;
  reg [2:0] s2;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // Two stages on each pin; idle line and deasserted handshakes after reset
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 3'h1;
      s2 <= 3'h1;
    end else begin
      s1 <= {cts_i, dsr_i, rxd_i};
      s2 <= s1;
    end
  end
  wire rxd = s2[0];
  wire dsr = s2[1];
  wire cts = s2[2];

  //////////////////////////////////////////////////////////////////////////
  // Settings: no reset, so neither preset nor reset disturbs them;
  // power persistence is the job of the nonvolatile store feeding cfg_*
  initial baud_o = `RSP_BAUD_9600;
  initial flow_o = `RSP_FLOW_NONE;
  always @(posedge clk_i) begin
    if (cfg_we_i && cfg_baud_i <= `RSP_BAUD_115200) begin
      baud_o <= cfg_baud_i;
    end
    if (cfg_we_i && cfg_flow_i <= `RSP_FLOW_MODEM) begin
      flow_o <= cfg_flow_i;
    end
  end

  // Oversample-by-16 tick divisor per rate, truncated
  reg [15:0] div16;
  always @* begin
    case (baud_o)
      `RSP_BAUD_4800:  div16 = `RSP_DIV_4800;
      `RSP_BAUD_9600:  div16 = `RSP_DIV_9600;
      `RSP_BAUD_19200: div16 = `RSP_DIV_19200;
      `RSP_BAUD_38400: div16 = `RSP_DIV_38400;
      `RSP_BAUD_57600: div16 = `RSP_DIV_57600;
      default:         div16 = `RSP_DIV_115200;
    endcase
  end

  reg [15:0] tick_cnt;
  reg        tick;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 16'h0;
      tick     <= 1'b0;
    end else if (tick_cnt >= div16) begin
      tick_cnt <= 16'h0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h1;
      tick     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver: 8N1, sampled mid-bit on the x16 tick
  localparam RX_IDLE = 3'h1;
  localparam RX_DATA = 3'h2;
  localparam RX_STOP = 3'h4;
  reg [2:0] rx_st;
  reg [3:0] rx_ph;
  reg [2:0] rx_bit;
  reg [7:0] rx_sh;
  reg       rx_done;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st   <= RX_IDLE;
      rx_ph   <= 4'h0;
      rx_bit  <= 3'h0;
      rx_sh   <= 8'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        case (rx_st)
          RX_IDLE: begin
            if (!rxd) begin
              rx_ph <= rx_ph + 4'h1;
              if (rx_ph == 4'h7) begin
                rx_ph  <= 4'h0;
                rx_bit <= 3'h0;
                rx_st  <= RX_DATA;
              end
            end else begin
              rx_ph <= 4'h0;
            end
          end
          RX_DATA: begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == 4'hf) begin
              rx_sh  <= {rxd, rx_sh[7:1]};
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == 3'h7) begin
                rx_st <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == 4'hf) begin
              rx_done <= rxd; // Framing errors dropped
              rx_st   <= RX_IDLE;
            end
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // In-band pause; in software mode the control characters are consumed, not buffered
  wire sw_mode = (flow_o == `RSP_FLOW_XONXOFF);
  wire is_xoff = sw_mode && rx_sh == `RSP_CHAR_XOFF;
  wire is_xon  = sw_mode && rx_sh == `RSP_CHAR_XON;
  reg  paused;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      paused <= 1'b0;
    end else if (!sw_mode) begin
      paused <= 1'b0;
    end else if (rx_done && is_xoff) begin
      paused <= 1'b1;
    end else if (rx_done && is_xon) begin
      paused <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive buffer with fill count
  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  reg           rd_pend;
  reg  [AW-1:0] wp;
  reg  [AW-1:0] rp;
  reg  [AW:0]   fill;
  wire [7:0]    mem_q;
  wire push = rx_done && !is_xoff && !is_xon && fill != DEPTH;
  wire pop  = fill != {(AW+1){1'b0}} && (!rx_valid_o || rx_ready_i) && !rd_pend;

  rsp_rx_mem #(.AW(AW)) u_mem (
    .clk_i   (clk_i),
    .we_i    (push),
    .waddr_i (wp),
    .wdata_i (rx_sh),
    .raddr_i (rp),
    .rdata_o (mem_q)
  );

  // Pointers, fill level and registered output stage
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wp           <= {AW{1'b0}};
      rp           <= {AW{1'b0}};
      fill         <= {(AW+1){1'b0}};
      rd_pend      <= 1'b0;
      rx_valid_o   <= 1'b0;
      rx_data_o    <= 8'h0;
      rx_overrun_o <= 1'b0;
    end else begin
      rx_overrun_o <= rx_done && !is_xoff && !is_xon && fill == DEPTH;
      if (push) begin
        wp <= wp + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp <= rp + {{(AW-1){1'b0}}, 1'b1};
      end
      fill    <= fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      rd_pend <= pop;
      if (rd_pend) begin
        rx_valid_o <= 1'b1;
        rx_data_o  <= mem_q;
      end else if (rx_ready_i) begin
        rx_valid_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Handshake outputs with hysteresis so the line does not chatter
  wire hw_dtr = flow_o == `RSP_FLOW_DTRDSR || flow_o == `RSP_FLOW_MODEM;
  wire hw_rts = flow_o == `RSP_FLOW_RTSCTS || flow_o == `RSP_FLOW_MODEM;
  reg  full_ish;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      full_ish <= 1'b0;
      dtr_o    <= 1'b0;
      rts_o    <= 1'b0;
    end else begin
      if (fill >= `RSP_RX_HIGH) begin
        full_ish <= 1'b1;
      end else if (fill <= `RSP_RX_LOW) begin
        full_ish <= 1'b0;
      end
      dtr_o <= hw_dtr ? !full_ish : 1'b1;
      rts_o <= hw_rts ? !full_ish : 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit permission, checked only between characters
  wire tx_ok = !paused &&
               (!hw_dtr || dsr) &&
               (!hw_rts || cts);

  localparam TX_IDLE = 2'h1;
  localparam TX_SEND = 2'h2;
  reg [1:0] tx_st;
  reg [3:0] tx_ph;
  reg [3:0] tx_bit;
  reg [9:0] tx_sh;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st      <= TX_IDLE;
      tx_ph      <= 4'h0;
      tx_bit     <= 4'h0;
      tx_sh      <= 10'h3ff;
      txd_o      <= 1'b1;
      tx_ready_o <= 1'b0;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          txd_o      <= 1'b1;
          tx_ready_o <= tx_ok && !tx_ready_o;
          if (tx_ready_o && tx_valid_i) begin
            tx_sh      <= {1'b1, tx_data_i, 1'b0};
            tx_ph      <= 4'h0;
            tx_bit     <= 4'h0;
            tx_ready_o <= 1'b0;
            tx_st      <= TX_SEND;
          end
        end
        TX_SEND: begin
          tx_ready_o <= 1'b0;
          txd_o      <= tx_sh[0];
          if (tick) begin
            tx_ph <= tx_ph + 4'h1;
            if (tx_ph == 4'hf) begin
              tx_sh  <= {1'b1, tx_sh[9:1]};
              tx_bit <= tx_bit + 4'h1;
              if (tx_bit == 4'h9) begin
                tx_st <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end
endmodule // rsp_port
`default_nettype wire

/* File: dv/rsp_port_chk.sv */
`include "rsp_regs.vh"
`default_nettype none
// Cycle relations between the port pins
module rsp_port_chk (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       cfg_we_i,
  input wire logic [2:0] cfg_baud_i,
  input wire logic [2:0] cfg_flow_i,
  input wire logic [2:0] baud_o,
  input wire logic [2:0] flow_o,
  input wire logic       tx_valid_i,
  input wire logic       tx_ready_o,
  input wire logic       rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       rx_ready_i,
  input wire logic       txd_o,
  input wire logic       dsr_i,
  input wire logic       cts_i,
  input wire logic       dtr_o,
  input wire logic       rts_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Modes gating on each line; the sync flops need several low cycles
  wire logic dsr_md = flow_o == `RSP_FLOW_DTRDSR || flow_o == `RSP_FLOW_MODEM;
  wire logic cts_md = flow_o == `RSP_FLOW_RTSCTS || flow_o == `RSP_FLOW_MODEM;
  property p_load;
    cfg_we_i && cfg_baud_i <= `RSP_BAUD_115200 && cfg_flow_i <= `RSP_FLOW_MODEM |=>
      {baud_o, flow_o} == $past({cfg_baud_i, cfg_flow_i});
  endproperty
  a_load: assert property (p_load) else $error("setting not loaded");
  property p_hold; !cfg_we_i |=> $stable({baud_o, flow_o}); endproperty
  a_hold: assert property (p_hold) else $error("setting changed");
  // The line still shows idle in the cycle after the take; the start bit follows one edge later
  property p_start; tx_ready_o && tx_valid_i |=> ##1 !txd_o [*8]; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_dsr; (dsr_md && !dsr_i) [*4] |-> !tx_ready_o; endproperty
  a_dsr: assert property (p_dsr) else $error("sent with dsr false");
  property p_cts; (cts_md && !cts_i) [*4] |-> !tx_ready_o; endproperty
  a_cts: assert property (p_cts) else $error("sent with cts false");
  property p_dtr; !dsr_md [*8] |-> dtr_o; endproperty
  a_dtr: assert property (p_dtr) else $error("dtr false");
  property p_rts; !cts_md [*8] |-> rts_o; endproperty
  a_rts: assert property (p_rts) else $error("rts false");
  property p_rx; rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o); endproperty
  a_rx: assert property (p_rx) else $error("rx byte dropped");
  c_take: cover property (tx_ready_o && tx_valid_i);
  c_rx: cover property (rx_valid_o && rx_ready_i);
  c_refuse: cover property (cts_md && !cts_i && tx_valid_i);
endmodule // rsp_port_chk
bind rsp_port rsp_port_chk rsp_port_chk_inst (.clk_i, .resetn_i, .cfg_we_i, .cfg_baud_i, .cfg_flow_i, .baud_o,
  .flow_o, .tx_valid_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i, .txd_o, .dsr_i, .cts_i, .dtr_o, .rts_o);
`default_nettype wire

/* File: dv/rsp_host_model.sv */
`default_nettype none
// Far terminal: decodes device frames, sends frames on the receive line
module rsp_host_model #(
  parameter int BIT = 1088
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output var  logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got = 8'h00;
  int         n_got = 0;
  initial rxd_o = 1'b1;
  // Mid-cell sampling; a low stop bit leaves the frame uncounted
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk_i);
      if (i < 8) got[i] = txd_i;
      else if (txd_i) n_got++;
    end
  end
  // Line rests at mark between frames; also sends pause and resume
  task send(input logic [7:0] v);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : v[i - 1];
      repeat (BIT) @(posedge clk_i);
    end
  endtask
endmodule // rsp_host_model
`default_nettype wire

/* File: dv/rsp_port_tb.sv */
`include "rsp_regs.vh"
`default_nettype none
module rsp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i, resetn_i, cfg_we_i, tx_valid_i, rx_ready_i, dsr_i, cts_i, tk;
  logic       tx_ready_o, rx_valid_o, rx_overrun_o, txd_o, rxd_i, dtr_o, rts_o;
  logic [2:0] cfg_baud_i, cfg_flow_i, baud_o, flow_o;
  logic [7:0] tx_data_i, rx_data_o, d, d2;
  logic       ovr;
  int         fail_count = 0, tests_run = 0, cyc = 0;
  rsp_port rsp_port_inst (.clk_i, .resetn_i, .cfg_we_i, .cfg_baud_i, .cfg_flow_i, .baud_o, .flow_o, .tx_valid_i,
    .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i, .rx_overrun_o, .txd_o, .rxd_i, .dsr_i, .cts_i,
    .dtr_o, .rts_o);
  rsp_host_model rsp_host_model_inst (.clk_i, .txd_i(txd_o), .rxd_o(rxd_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Hang guard, about a third above the expected run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      summarize;
    end
  end
  // Any lost receive byte is remembered for a closing check
  always @(posedge clk_i) begin
    if (rx_overrun_o === 1'b1) ovr <= 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task set_cfg(input logic [2:0] b, input logic [2:0] f);
    cfg_baud_i = b;
    cfg_flow_i = f;
    cfg_we_i = 1'b1;
    tick(1);
    cfg_we_i = 1'b0;
    tick(1);
  endtask
  task offer(input logic [7:0] v);
    tx_data_i = v;
    tx_valid_i = 1'b1;
  endtask
  // Valid stays up until taken, so a refusal keeps the byte pending;
  // ready seen now is sampled high at the next edge, which is the take
  task take(input int n);
    tk = 1'b0;
    for (int i = 0; i < n && !tk; i++) begin
      tk = tx_ready_o === 1'b1;
      tick(1);
    end
    if (tk) tx_valid_i = 1'b0;
  endtask
  // Spare cycles cover the rest of the stop bit before the next offer
  task get;
    int n0;
    n0 = rsp_host_model_inst.n_got;
    for (int i = 0; i < 12000 && rsp_host_model_inst.n_got == n0; i++) tick(1);
    d = rsp_host_model_inst.got;
    tick(600);
  endtask
  task rx_get;
    rx_ready_i = 1'b0;
    for (int i = 0; i < 12000 && rx_valid_o !== 1'b1; i++) tick(1);
    tick(3);
    d2 = rx_data_o;
    rx_ready_i = 1'b1;
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////
  // Rate and mode codes read back; bad codes leave them alone, reset leaves the mode alone
  task t_cfg;
    for (int b = 0; b < 6; b++) begin
      set_cfg(b[2:0], 3'h0);
      check("baud", {5'h0, baud_o}, {5'h0, b[2:0]});
    end
    for (int f = 0; f < 5; f++) begin
      set_cfg(3'h7, f[2:0]);
      check("flow", {2'h0, baud_o, flow_o}, {5'h5, f[2:0]});
    end
    resetn_i = 1'b0;
    tick(2);
    resetn_i = 1'b1;
    tick(8);
    set_cfg(3'h5, 3'h7);
    check("keep", {2'h0, baud_o, flow_o}, 8'h2c);
  endtask
  // Both directions at once with both handshake lines false
  task t_none;
    set_cfg(3'h5, `RSP_FLOW_NONE);
    offer(8'ha5);
    fork
      rsp_host_model_inst.send(8'h3c);
      begin
        take(100);
        get;
      end
      rx_get;
    join
    check("take", {7'h0, tk}, 8'h01);
    check("txd", d, 8'ha5);
    check("rxd", d2, 8'h3c);
  endtask
  task t_xon;
    set_cfg(3'h5, `RSP_FLOW_XONXOFF);
    rsp_host_model_inst.send(`RSP_CHAR_XOFF);
    tick(10);
    offer(8'h5a);
    take(2000);
    check("paused", {7'h0, tk}, 8'h00);
    // Resume comes at the stop bit of the resume frame, so watch for it meanwhile
    fork
      rsp_host_model_inst.send(`RSP_CHAR_XON);
      take(12000);
    join
    get;
    check("resume", {7'h0, tk, d}, 9'h15a);
  endtask
  // Each line alone true is not enough
  task t_modem;
    set_cfg(3'h5, `RSP_FLOW_MODEM);
    dsr_i = 1'b1;
    offer(8'hc3);
    take(300);
    check("modem dsr", {7'h0, tk}, 8'h00);
    dsr_i = 1'b0;
    cts_i = 1'b1;
    take(300);
    check("modem cts", {7'h0, tk}, 8'h00);
  endtask
  task t_rts;
    cts_i = 1'b0;
    tick(4); // Let the false level pass the pin flops before the mode change
    set_cfg(3'h5, `RSP_FLOW_RTSCTS);
    take(300);
    check("cts low", {7'h0, tk}, 8'h00);
    cts_i = 1'b1;
    take(100);
    get;
    check("cts high", {7'h0, tk, d}, 9'h1c3);
  endtask
  task t_dtr;
    dsr_i = 1'b0;
    set_cfg(3'h5, `RSP_FLOW_DTRDSR);
    offer(8'h96);
    take(300);
    check("dsr low", {7'h0, tk}, 8'h00);
    dsr_i = 1'b1;
    take(100);
    get;
    check("dsr high", {7'h0, tk, d}, 9'h196);
    check("lines", {6'h0, dtr_o, rts_o}, 8'h03);
    check("overrun", {7'h0, ovr}, 8'h00);
  endtask
  initial begin
    {resetn_i, cfg_we_i, cfg_baud_i, cfg_flow_i, tx_valid_i, tx_data_i, dsr_i, cts_i, ovr} = '0;
    rx_ready_i = 1'b1;
    tick(10);
    resetn_i = 1'b1;
    tick(8);
    t_cfg;
    t_none;
    t_xon;
    t_modem;
    t_rts;
    t_dtr;
    summarize;
  end
endmodule // rsp_port_tb
`default_nettype wire
